// ===== test/dms_decoder_tb.sv
`timescale 1ns/10ps
// Random and corner accesses checked against a reference of every space
module dms_decoder_tb;
  logic              mclk = 1'b0;                        // Core clock
  logic              nrst = 1'b0;                        // Reset, active low
  logic              req_valid = 1'b0;                   // Request strobe
  dms_pkg::dms_req_t req = '0;                           // Request fields
  logic [15:0]       data_pointer = 16'h0000;            // Pointer inputs
  logic [15:0]       pc = 16'h0000;
  logic [7:0]        working_pointer_register = 8'h00;
  logic [7:0]        acc = 8'h00;
  logic [2:0]        ext_ram_page = 3'h0;
  logic              req_ready, rsp_valid, code_rd;      // Decoder outputs
  dms_pkg::dms_rsp_t rsp;
  dms_pkg::dms_spr_t spr;
  logic [15:0]       code_addr;
  logic [7:0]        spr_rdata, code_rdata;              // Far-side answers
  logic [7:0]        iram_e [256];                       // Expected internal RAM
  logic [7:0]        spr_e [128];                        // Expected special registers
  logic [7:0]        ext_e [2048];                       // Expected extended RAM
  logic [31:0]       seed = 32'h00000020;                // Xorshift state
  int                error_cnt = 0;
  int                check_count = 0;

  // Clock generator
  always #2.5 mclk = ~mclk;

  dms_decoder u_dms_decoder (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .data_pointer(data_pointer),
    .working_pointer_register(working_pointer_register), .ext_ram_page(ext_ram_page),
    .acc(acc), .pc(pc), .rsp_valid(rsp_valid), .rsp(rsp), .spr(spr), .spr_rdata(spr_rdata),
    .code_rd(code_rd), .code_addr(code_addr), .code_rdata(code_rdata));
  dms_far_model u_dms_far_model (.mclk(mclk), .spr(spr), .spr_rdata(spr_rdata),
    .code_rd(code_rd), .code_addr(code_addr), .code_rdata(code_rdata));

  // Repeatable random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Answer latency per addressing mode
  function automatic int lat_of(input dms_pkg::dms_mode_t m);
    case (m)
      dms_pkg::MODE_REG: return int'(dms_pkg::LAT_REG);
      dms_pkg::MODE_DIRECT: return int'(dms_pkg::LAT_DIR);
      dms_pkg::MODE_INDIRECT: return int'(dms_pkg::LAT_IND);
      dms_pkg::MODE_IMMEDIATE: return int'(dms_pkg::LAT_IMM);
      dms_pkg::MODE_BIT: return int'(dms_pkg::LAT_BIT);
      dms_pkg::MODE_EXT_DIRECT, dms_pkg::MODE_EXT_INDIRECT: return int'(dms_pkg::LAT_EXT);
      default: return int'(dms_pkg::LAT_CODE);
    endcase
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    check_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One access: issue, wait for the answer, compare, update the reference
  task automatic op(input dms_pkg::dms_mode_t m, input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    logic [15:0] ea;
    logic [7:0]  ba, ex, wb;
    logic [1:0]  sp;
    logic        er;
    int          n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req       <= '{mode: m, wr: w, addr: a, wdata: d, bit_val: d[0]};
    @(negedge mclk);
    ea = 16'h0000;
    er = 1'b0;
    ex = 8'hFF;
    case (m)
      dms_pkg::MODE_EXT_DIRECT: ea = data_pointer;
      dms_pkg::MODE_EXT_INDIRECT: ea = {5'h00, ext_ram_page, working_pointer_register};
      dms_pkg::MODE_IMMEDIATE: ea = pc;
      dms_pkg::MODE_CODE_DP: ea = data_pointer + {8'h00, acc};
      dms_pkg::MODE_CODE_PC: ea = pc + {8'h00, acc};
      default: ;
    endcase
    sp = (m inside {dms_pkg::MODE_EXT_DIRECT, dms_pkg::MODE_EXT_INDIRECT}) ? 2'h2 :
         (m inside {dms_pkg::MODE_IMMEDIATE, dms_pkg::MODE_CODE_DP, dms_pkg::MODE_CODE_PC})
         ? 2'h3 : (m inside {dms_pkg::MODE_DIRECT, dms_pkg::MODE_BIT}) ? {1'b0, a[7]} : 2'h0;
    ba = (m != dms_pkg::MODE_BIT) ? a : a[7] ? {a[7:3], 3'h0} : 8'h20 + {4'h0, a[6:3]};
    case (sp)
      2'h0: ex = iram_e[ba];
      2'h1: ex = spr_e[ba[6:0]];
      2'h2: if (ea < dms_pkg::EXT_RAM_BYTES) ex = ext_e[ea[10:0]]; else er = 1'b1;
      default: if (ea < dms_pkg::CODE_BYTES) ex = ea[7:0] ^ ea[15:8] ^ 8'hA5; else er = 1'b1;
    endcase
    er = er | (w && sp == 2'h3);
    wb = ex;
    wb[a[2:0]] = d[0];
    wb = (m == dms_pkg::MODE_BIT) ? wb : d;
    chk("ready", 16'h0001, {15'h0000, req_ready});
    @(posedge mclk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      @(negedge mclk);
    end while (rsp_valid !== 1'b1 && n < 8);
    chk("latency", 16'(lat_of(m)), 16'(n));
    chk("err", {15'h0000, er}, {15'h0000, rsp.err});
    if (!w) chk("rdata", {8'h00, ex}, {8'h00, rsp.rdata});
    if (!w && m == dms_pkg::MODE_BIT) chk("bit", {15'h0000, ex[a[2:0]]}, {15'h0000, rsp.bit_val});
    if (w && !er && sp == 2'h0) iram_e[ba] = wb;
    if (w && !er && sp == 2'h1) spr_e[ba[6:0]] = wb;
    if (w && !er && sp == 2'h2) ext_e[ea[10:0]] = wb;
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the expected 19k cycles
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence: fill, random traffic, corners
  initial begin
    dms_pkg::dms_mode_t md;
    for (int i = 0; i < 128; i++) spr_e[i] = 8'h00;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 256; i++) op(dms_pkg::MODE_INDIRECT, 1'b1, 8'(i), 8'(rnd()));
    for (int i = 0; i < 2048; i++) begin
      @(posedge mclk);
      data_pointer <= 16'(i);
      op(dms_pkg::MODE_EXT_DIRECT, 1'b1, 8'h00, 8'(rnd()));
    end
    for (int k = 0; k < 600; k++) begin
      @(posedge mclk);
      data_pointer <= {4'h0, 12'(rnd())};
      working_pointer_register <= 8'(rnd());
      ext_ram_page <= 3'(rnd());
      acc <= 8'(rnd());
      pc <= 16'(rnd());
      md = dms_pkg::dms_mode_t'(4'(rnd() % 9));
      op(md, md != dms_pkg::MODE_IMMEDIATE && rnd() % 2 == 1, 8'(rnd()), 8'(rnd()));
    end
    @(posedge mclk);
    data_pointer <= 16'h07FF;
    pc <= 16'hF7FF;
    acc <= 8'h00;
    working_pointer_register <= 8'hFF;
    ext_ram_page <= 3'h7;
    op(dms_pkg::MODE_EXT_INDIRECT, 1'b0, 8'h00, 8'h00);
    op(dms_pkg::MODE_CODE_PC, 1'b0, 8'h00, 8'h00);
    op(dms_pkg::MODE_BIT, 1'b1, 8'h80, 8'h01);
    op(dms_pkg::MODE_DIRECT, 1'b0, 8'h80, 8'h00);
    op(dms_pkg::MODE_BIT, 1'b0, 8'h7F, 8'h00);
    @(posedge mclk);
    data_pointer <= 16'h0800;
    acc <= 8'h01;
    op(dms_pkg::MODE_EXT_DIRECT, 1'b1, 8'h00, 8'h3C);
    op(dms_pkg::MODE_EXT_DIRECT, 1'b0, 8'h00, 8'h00);
    op(dms_pkg::MODE_CODE_PC, 1'b0, 8'h00, 8'h00);
    op(dms_pkg::MODE_CODE_DP, 1'b1, 8'h00, 8'h00);
    end_of_test();
  end
endmodule // dms_decoder_tb

// ===== test/dms_far_model.sv
`timescale 1ns/10ps
// Stand-in for the special register space and the code flash beyond the decoder
module dms_far_model (
  input  wire logic              mclk,
  input  wire dms_pkg::dms_spr_t spr,
  output logic [7:0]             spr_rdata,
  input  wire logic              code_rd,
  input  wire logic [15:0]       code_addr,
  output logic [7:0]             code_rdata
);
  logic [7:0] regs [128];  // Register contents, those at multiples of eight bit addressable
  logic [7:0] churn_r = 8'h5A;  // Filler that changes every cycle while unselected

  // Registers start cleared so the bench can predict them
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'h00;
    end
  end

  // Writes land at the edge that closes the select cycle
  always @(posedge mclk) begin
    churn_r <= ~churn_r;
    if (spr.sel && spr.wr) begin
      regs[spr.addr[6:0]] <= spr.wdata;
    end
  end

  // Combinational read, filler when not selected so stale data never looks right
  assign spr_rdata  = spr.sel ? regs[spr.addr[6:0]] : churn_r;
  // Flash holds a fixed pattern of its address
  assign code_rdata = code_rd ? (code_addr[7:0] ^ code_addr[15:8] ^ 8'hA5) : churn_r;
endmodule // dms_far_model

// ===== verilog/dms_decoder.sv
`timescale 1ns/10ps
// How it works
// - 256-byte internal RAM holds register banks
// - Low 128 bytes reached direct or indirect
// - Direct 0x80-0xFF goes to special registers
// - Indirect 0x80-0xFF goes to upper RAM
// - Special registers answer direct and bit accesses only
// - Bit 0x00-0x7F maps bytes 0x20-0x2F ascending
// - Bit writes done in hardware, no masking
// - Special register bits reachable by bit address
// - 2 kB extended RAM, extended moves only
// - No external data bus, extended RAM serves
// - 62 kB code space, read via code modes
// - Extended direct address from data pointer
// - Extended indirect address from working pointer
// - Immediate literal fetched from code, slower
// - Register-to-register direct mode is fastest
module dms_decoder #(
  parameter int EXT_RAM_BYTES = dms_pkg::EXT_RAM_BYTES,  // Extended RAM size
  parameter int CODE_BYTES    = dms_pkg::CODE_BYTES      // Code space size
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              req_valid,
  input  wire dms_pkg::dms_req_t req,
  output logic                   req_ready,
  input  wire logic [15:0]       data_pointer,
  input  wire logic [7:0]        working_pointer_register,
  input  wire logic [2:0]        ext_ram_page,
  input  wire logic [7:0]        acc,
  input  wire logic [15:0]       pc,
  output logic                   rsp_valid,
  output dms_pkg::dms_rsp_t      rsp,
  output dms_pkg::dms_spr_t      spr,
  input  wire logic [7:0]        spr_rdata,
  output logic                   code_rd,
  output logic [15:0]            code_addr,
  input  wire logic [7:0]        code_rdata
);

  // Replace one bit of a byte
  function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] i,
                                         input logic v);
    logic [7:0] r;
    r    = b;
    r[i] = v;
    return r;
  endfunction

  // Storage and sequencer state
  logic [7:0]                iram    [dms_pkg::IRAM_BYTES];  // Internal RAM
  logic [7:0]                ext_ram [EXT_RAM_BYTES];        // Extended RAM
  dms_pkg::dms_state_t       state_r;                        // Sequencer state
  logic [dms_pkg::LAT_W-1:0] cnt_r;                          // Cycles left
  dms_pkg::dms_req_t         cur_r;                          // Latched request
  logic [15:0]               ext_addr_r;                     // Extended address
  logic [15:0]               code_addr_r;                    // Code address
  logic                      rsp_valid_r;                    // Answer strobe
  dms_pkg::dms_rsp_t         rsp_r;                          // Answer data

  // Request acceptance and per-mode latency
  // Only one access is in flight, so the core waits on req_ready
  wire                       take = req_valid && (state_r == dms_pkg::ST_IDLE);
  wire [dms_pkg::LAT_W-1:0]  lat_sel =
    (req.mode == dms_pkg::MODE_REG)      ? dms_pkg::LAT_REG :
    (req.mode == dms_pkg::MODE_DIRECT)   ? dms_pkg::LAT_DIR :
    (req.mode == dms_pkg::MODE_INDIRECT) ? dms_pkg::LAT_IND :
    (req.mode == dms_pkg::MODE_IMMEDIATE)? dms_pkg::LAT_IMM :
    (req.mode == dms_pkg::MODE_BIT)      ? dms_pkg::LAT_BIT :
    (req.mode == dms_pkg::MODE_EXT_DIRECT ||
     req.mode == dms_pkg::MODE_EXT_INDIRECT) ? dms_pkg::LAT_EXT : dms_pkg::LAT_CODE;

  // Address sources picked at acceptance
  // Pointers are sampled once, so the core may move them while busy
  wire [15:0] ext_sel  = (req.mode == dms_pkg::MODE_EXT_DIRECT) ? data_pointer
                       : {5'h00, ext_ram_page, working_pointer_register};
  wire [15:0] code_sel =
    (req.mode == dms_pkg::MODE_IMMEDIATE) ? pc :
    (req.mode == dms_pkg::MODE_CODE_DP)   ? 16'(data_pointer + {8'h00, acc}) :
                                            16'(pc + {8'h00, acc});

  // Decode of the latched access
  // Every target but the code flash is chosen in the last busy cycle only
  wire       fire     = (state_r == dms_pkg::ST_BUSY) && (cnt_r == '0);
  wire       is_hi    = cur_r.addr >= dms_pkg::SPR_FIRST;
  wire       m_bit    = cur_r.mode == dms_pkg::MODE_BIT;
  wire       m_ext    = (cur_r.mode == dms_pkg::MODE_EXT_DIRECT) ||
                        (cur_r.mode == dms_pkg::MODE_EXT_INDIRECT);
  wire       m_code   = (cur_r.mode == dms_pkg::MODE_IMMEDIATE) ||
                        (cur_r.mode == dms_pkg::MODE_CODE_DP) ||
                        (cur_r.mode == dms_pkg::MODE_CODE_PC);
  wire [2:0] bit_idx  = cur_r.addr[2:0];
  wire [7:0] bit_byte = is_hi ? {cur_r.addr[7:3], 3'h0}
                              : 8'(dms_pkg::BIT_RAM_BASE + {4'h0, cur_r.addr[6:3]});
  wire       spr_byte = fire && (cur_r.mode == dms_pkg::MODE_DIRECT) && is_hi;
  wire       spr_bit  = fire && m_bit && is_hi;
  wire       iram_hit = fire && ((cur_r.mode == dms_pkg::MODE_REG) ||
                                 (cur_r.mode == dms_pkg::MODE_INDIRECT) ||
                                 ((cur_r.mode == dms_pkg::MODE_DIRECT) && !is_hi) ||
                                 (m_bit && !is_hi));
  wire [7:0] iram_addr = m_bit ? bit_byte : cur_r.addr;
  wire [7:0] iram_q    = iram[iram_addr];
  wire       ext_ok    = 32'(ext_addr_r) < EXT_RAM_BYTES;
  wire       code_ok   = 32'(code_addr_r) < CODE_BYTES;
  wire       ext_hit   = fire && m_ext && ext_ok;
  wire [7:0] ext_q     = ext_ok ? ext_ram[ext_addr_r[$clog2(EXT_RAM_BYTES)-1:0]]
                                : dms_pkg::BLANK_BYTE;

  // Bit writes merge in hardware so software never masks
  wire [7:0] iram_wbyte = m_bit ? set_bit(iram_q, bit_idx, cur_r.bit_val) : cur_r.wdata;
  wire [7:0] spr_wbyte  = spr_bit ? set_bit(spr_rdata, bit_idx, cur_r.bit_val)
                                  : cur_r.wdata;

  // Byte returned for the finished access
  // Out-of-range reads give a blank byte rather than stale data
  wire [7:0] rd_byte = (spr_byte || spr_bit) ? spr_rdata :
                       m_ext  ? ext_q :
                       m_code ? (code_ok ? code_rdata : dms_pkg::BLANK_BYTE) : iram_q;
  wire       rd_err  = (m_ext && !ext_ok) || (m_code && (!code_ok || cur_r.wr));

  // Outward strobes
  assign req_ready = state_r == dms_pkg::ST_IDLE;
  assign spr.sel   = spr_byte || spr_bit;
  assign spr.wr    = (spr_byte || spr_bit) && cur_r.wr;
  assign spr.addr  = spr_bit ? bit_byte : cur_r.addr;
  assign spr.wdata = spr_wbyte;
  assign code_rd   = (state_r == dms_pkg::ST_BUSY) && m_code && code_ok;
  assign code_addr = code_addr_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp       = rsp_r;

  // Sequencer: take a request, count its latency, answer
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r     <= dms_pkg::ST_IDLE;
      cnt_r       <= '0;
      cur_r       <= '0;
      ext_addr_r  <= '0;
      code_addr_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      rsp_valid_r <= fire;
      if (take) begin
        // Latch request and its address sources
        state_r     <= dms_pkg::ST_BUSY;
        cnt_r       <= lat_sel - 3'h1;
        cur_r       <= req;
        ext_addr_r  <= ext_sel;
        code_addr_r <= code_sel;
      end else if (fire) begin
        // Finish access and present answer
        state_r       <= dms_pkg::ST_IDLE;
        rsp_r.rdata   <= rd_byte;
        rsp_r.bit_val <= rd_byte[bit_idx];
        rsp_r.err     <= rd_err;
      end else if (state_r == dms_pkg::ST_BUSY) begin
        // Wait out the mode's cycles
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

  // Internal RAM write port
  always_ff @(posedge mclk) begin
    if (iram_hit && cur_r.wr) begin
      iram[iram_addr] <= iram_wbyte;
    end
  end

  // Extended RAM write port
  always_ff @(posedge mclk) begin
    if (ext_hit && cur_r.wr) begin
      ext_ram[ext_addr_r[$clog2(EXT_RAM_BYTES)-1:0]] <= cur_r.wdata;
    end
  end

  // Helpers for checks
  logic [2:0] busy_cnt;  // Cycles since acceptance
  always_ff @(posedge mclk) begin
    if (!nrst || take) begin
      busy_cnt <= '0;
    end else if (state_r == dms_pkg::ST_BUSY) begin
      busy_cnt <= busy_cnt + 3'h1;
    end
  end

  // Special registers are only reached by direct or bit accesses
  spr_direct_only_a: assert property (@(posedge mclk) disable iff (!nrst)
    spr.sel |-> (cur_r.mode == dms_pkg::MODE_DIRECT || m_bit) && cur_r.addr[7])
    else $error("special register reached by a non-direct access");

  // Indirect writes land in internal RAM at any address
  high_indirect_ram_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && cur_r.mode == dms_pkg::MODE_INDIRECT && cur_r.wr)
      |=> !$past(spr.sel) && iram[$past(cur_r.addr)] == $past(cur_r.wdata))
    else $error("indirect write missed internal RAM");

  // Indirect accesses never strobe the special registers
  indirect_no_spr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && cur_r.mode == dms_pkg::MODE_INDIRECT) |-> !spr.sel)
    else $error("indirect access strobed a special register");

  // Low direct writes land in internal RAM
  low_direct_ram_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && cur_r.mode == dms_pkg::MODE_DIRECT && !is_hi && cur_r.wr)
      |=> iram[$past(cur_r.addr)] == $past(cur_r.wdata))
    else $error("direct low write missed internal RAM");

  // High direct accesses go out to the special registers
  high_direct_spr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && cur_r.mode == dms_pkg::MODE_DIRECT && is_hi) |-> spr.sel && !iram_hit)
    else $error("direct high access not sent to special registers");

  // Low bit addresses hit the right RAM bit
  bit_ram_map_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && m_bit && !is_hi && cur_r.wr)
      |=> iram[dms_pkg::BIT_RAM_BASE + $past(cur_r.addr[6:3])][$past(cur_r.addr[2:0])]
          == $past(cur_r.bit_val))
    else $error("bit address landed on the wrong RAM bit");

  // High bit addresses hit a register on a multiple of eight
  spr_bit_map_a: assert property (@(posedge mclk) disable iff (!nrst)
    spr_bit |-> spr.addr[2:0] == 3'h0 && spr.addr[7:3] == cur_r.addr[7:3])
    else $error("special register bit mapped to wrong byte");

  // A register bit write leaves the other seven bits alone
  spr_bit_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    (spr_bit && cur_r.wr) |-> ((spr.wdata ^ spr_rdata) & ~(8'h01 << bit_idx)) == 8'h00)
    else $error("register bit write disturbed other bits");

  // Register accesses answer one edge after the take edge
  reg_fastest_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && req.mode == dms_pkg::MODE_REG) |=> ##1 rsp_valid)
    else $error("register access not answered in one cycle");

  // No new request is taken while busy
  busy_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
    take |=> !req_ready)
    else $error("request accepted while busy");

  // The answer strobe is a single pulse
  rsp_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");

  // Immediate literals come through the code space in two cycles
  imm_two_cycles_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && req.mode == dms_pkg::MODE_IMMEDIATE && 32'(code_sel) < CODE_BYTES)
      |=> code_rd [*2] ##1 rsp_valid)
    else $error("immediate fetch not two cycles through code");

  // Extended direct accesses answer four edges after the take edge
  ext_four_cycles_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && req.mode == dms_pkg::MODE_EXT_DIRECT) |=> !rsp_valid [*4] ##1 rsp_valid)
    else $error("extended access not answered in four cycles");

  // Extended writes in range land in extended RAM
  ext_ram_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ext_hit && cur_r.wr)
      |=> ext_ram[$past(ext_addr_r[$clog2(EXT_RAM_BYTES)-1:0])] == $past(cur_r.wdata))
    else $error("extended write missed extended RAM");

  // Extended addresses past the RAM report an error and a blank byte
  ext_range_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && m_ext && !ext_ok) |=> rsp.err && rsp.rdata == dms_pkg::BLANK_BYTE)
    else $error("extended access out of range not refused");

  // Extended direct address comes from the data pointer
  ext_dp_addr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && req.mode == dms_pkg::MODE_EXT_DIRECT) |=> ext_addr_r == $past(data_pointer))
    else $error("extended direct address not from data pointer");

  // Extended indirect address comes from the working pointer and page
  ext_ptr_addr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && req.mode == dms_pkg::MODE_EXT_INDIRECT)
      |=> ext_addr_r == {5'h00, $past(ext_ram_page), $past(working_pointer_register)})
    else $error("extended indirect address not from working pointer");

  // Code reads only during a code access
  code_rd_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
    code_rd |-> m_code && busy_cnt < 3'h4)
    else $error("code read outside a code access");

  // Code address holds while the flash is being read
  code_addr_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (code_rd && !fire) |=> $stable(code_addr))
    else $error("code address moved during a code read");

  // Writes into the code space are refused
  code_write_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fire && m_code && cur_r.wr) |=> rsp.err)
    else $error("code space write not refused");

  // Nothing is strobed right after reset
  reset_quiet_a: assert property (@(posedge mclk)
    !nrst |=> !rsp_valid && !spr.sel && !code_rd)
    else $error("strobe active after reset");

endmodule // dms_decoder

// ===== verilog/dms_pkg.sv
package dms_pkg;

  // Storage sizes
  localparam int IRAM_BYTES = 256;
  localparam int EXT_RAM_BYTES = 2048;
  localparam int CODE_BYTES = 62 * 1024;

  // Address-space boundaries
  localparam logic [7:0] IRAM_LAST    = 8'hFF;
  localparam logic [7:0] SPR_FIRST    = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_RAM_LAST = 8'h2F;
  localparam logic [7:0] BLANK_BYTE   = 8'hFF;

  // Core cycles from request taken to answer, per addressing mode
  localparam int LAT_W = 3;
  localparam logic [LAT_W-1:0] LAT_REG  = 3'h1;
  localparam logic [LAT_W-1:0] LAT_DIR  = 3'h2;
  localparam logic [LAT_W-1:0] LAT_IND  = 3'h2;
  localparam logic [LAT_W-1:0] LAT_IMM  = 3'h2;
  localparam logic [LAT_W-1:0] LAT_BIT  = 3'h2;
  localparam logic [LAT_W-1:0] LAT_EXT  = 3'h4;
  localparam logic [LAT_W-1:0] LAT_CODE = 3'h4;

  // Addressing modes issued by the execution unit
  typedef enum logic [3:0] {
    MODE_REG, MODE_DIRECT, MODE_INDIRECT, MODE_IMMEDIATE, MODE_BIT,
    MODE_EXT_DIRECT, MODE_EXT_INDIRECT, MODE_CODE_DP, MODE_CODE_PC
  } dms_mode_t;

  // Access sequencer states
  typedef enum logic {ST_IDLE, ST_BUSY} dms_state_t;

  // Access request from the execution unit
  typedef struct packed {
    dms_mode_t  mode;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_val;
  } dms_req_t;

  // Answer to the execution unit
  typedef struct packed {
    logic [7:0] rdata;
    logic       bit_val;
    logic       err;
  } dms_rsp_t;

  // Strobe toward the special_function_register space
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dms_spr_t;

endpackage
